/* File: hdl/rtc_consts.svh */
// rtc_consts.svh: register map, field positions, reset values and timing counts
// assumes inclusion by the clock/calendar design files only
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH
`define DEV_ADDR 7'h51
`define OFS_CTRL1 8'h00
`define OFS_CTRL2 8'h01
`define OFS_SEC 8'h02
`define OFS_MIN 8'h03
`define OFS_HOUR 8'h04
`define OFS_DATE 8'h05
`define OFS_WDAY 8'h06
`define OFS_AL_MIN 8'h09
`define OFS_AL_HOUR 8'h0A
`define OFS_AL_DATE 8'h0B
`define OFS_AL_WDAY 8'h0C
`define C1_EXT_TICK_TEST_SELECT 7
`define C1_STOP 5
`define C1_RESET_OVERRIDE_PERMIT 3
`define C1_MASK 8'hA8
`define C2_TITP 4
`define C2_AF 3
`define C2_TF 2
`define C2_AIE 1
`define C2_TIE 0
`define SEC_OSF 7
`define AL_DIS 7
`define CTRL1_RST 8'h08
`define CTRL2_RST 8'h00
`define SEC_RST 8'h80
`define MASK_MIN 8'h7F
`define MASK_HOUR 8'h3F
`define MASK_DATE 8'h3F
`define MASK_WDAY 8'h07
`define MAX_SEC 8'h59
`define MAX_HOUR 8'h23
`define MAX_DATE 8'h31
`define MAX_WDAY 8'h06
`define MIN_DATE 8'h01
`define CLK_HZ 100000000
`define CLK_NS 10
`define TICK_HZ 64
`define PRESC_W 6
`define PRESC_FIRST 6'h1F
`define OVR_STEP_NS 1000
`define OVR_STEP_CYC ((`OVR_STEP_NS + `CLK_NS - 1) / `CLK_NS)
`define OVR_CNT_W 7
`endif

/* File: hdl/rtc_pkg.sv */
// rtc_pkg: state types of the serial slave and the reset-override detector
// assumes nothing beyond a SystemVerilog compiler
package rtc_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_DEV = 3'h1,
		ST_DEV_ACK = 3'h3,
		ST_RX = 3'h2,
		ST_RX_ACK = 3'h6,
		ST_TX = 3'h7,
		ST_TX_ACK = 3'h5
	} i2c_state_t;
	typedef enum logic [1:0] {
		OV_IDLE = 2'h0,
		OV_SDA_LOW = 2'h1,
		OV_SCL_LOW = 2'h3,
		OV_SDA_HIGH = 2'h2
	} ovr_step_t;
endpackage : rtc_pkg

/* File: hdl/tick_prescaler.sv */
// tick_prescaler: six-stage divider from the 64 Hz tick to the one-second strobe
// assumes i_tick is a one-cycle pulse on i_clk_sys
`include "rtc_consts.svh"
module tick_prescaler #(
	parameter int WIDTH = `PRESC_W
) (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_stop,
	input wire logic i_tick,
	output logic o_sec
);
	logic [WIDTH-1:0] cnt_q, cnt_d;
	logic sec_q, sec_d;

	// half-way compare gives 32 edges to the first second, 64 after
	always_comb begin
		cnt_d = cnt_q;
		sec_d = 1'b0;
		if (i_stop) begin
			cnt_d = '0;
		end else if (i_tick) begin
			cnt_d = cnt_q + 1'b1;
			sec_d = (cnt_q == WIDTH'(`PRESC_FIRST));
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_q <= '0;
			sec_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			sec_q <= sec_d;
		end
	end

	assign o_sec = sec_q;
endmodule : tick_prescaler

/* File: hdl/alarm_match.sv */
// alarm_match: compares enabled alarm fields with the running BCD time
// assumes all inputs are registers on the same clock
`include "rtc_consts.svh"
module alarm_match (
	input wire logic [7:0] i_min,
	input wire logic [7:0] i_hour,
	input wire logic [7:0] i_date,
	input wire logic [7:0] i_wday,
	input wire logic [7:0] i_al_min,
	input wire logic [7:0] i_al_hour,
	input wire logic [7:0] i_al_date,
	input wire logic [7:0] i_al_wday,
	output logic o_match
);
	logic [3:0][7:0] now, alarm, mask;
	logic [3:0] hit;

	assign now = {i_wday, i_date, i_hour, i_min};
	assign alarm = {i_al_wday, i_al_date, i_al_hour, i_al_min};
	assign mask = {`MASK_WDAY, `MASK_DATE, `MASK_HOUR, `MASK_MIN};

	for (genvar f = 0; f < 4; f++) begin : g_field
		// a set disable bit drops the field from the compare
		assign hit[f] = alarm[f][`AL_DIS] |
			((now[f] & mask[f]) == (alarm[f] & mask[f]));
	end

	assign o_match = &hit;
endmodule : alarm_match

/* File: hdl/rtc_alarm_test_i2c_slave.sv */
// rtc_alarm_test_i2c_slave: time registers, alarm, test tick, reset override, serial slave
// assumes open-drain pins resolved outside; i_por_active comes from the analog reset cell
//
// Contract
// - compare alarm field only when enabled
// - disabled alarm fields are ignored
// - set alarm flag when enabled fields match
// - flag sticky; re-set only on new match
// - alarm registers: disable bit plus BCD field
// - test bit turns square-wave pin into input
// - test mode: pin edges replace 64 Hz tick
// - six-stage prescaler, zero while stop set
// - first second after 32, then 64 edges
// - override sequence releases power-on reset at once
// - permit write 0 cancels; re-entry needs 1
// - permit clear otherwise only blocks entry
// - SDA edges with SCL high: start, stop
// - drive SDA while SCL low, sample high
// - unlimited bytes, address advances every byte
// - receiver acknowledges low on ninth clock
// - master nack ends read; slave releases SDA
// - answer only A2 write, A3 read
// - alarm flag write 0 clears, 1 keeps
// - alarm enable gates interrupt output
`include "rtc_consts.svh"
module rtc_alarm_test_i2c_slave #(
	parameter int TICK_DIV = `CLK_HZ / `TICK_HZ
) (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_por_active,
	input wire logic i_scl,
	input wire logic i_sda_in,
	output logic o_sda_out,
	output logic o_sda_oe,
	input wire logic i_sqw_in,
	output logic o_sqw_out,
	output logic o_sqw_oe,
	output logic o_int_out,
	output logic o_int_oe
);
	localparam int DIV_W = $clog2(TICK_DIV);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [3:0] pins, meta_q, sync_q;
	logic [2:0] prev_q;
	logic scl_s, sda_s, sqw_s, por_s;
	logic scl_rise, scl_fall, sda_rise, sda_fall, sqw_rise, any_edge;
	logic bus_start, bus_stop;

	assign pins = {i_por_active, i_sqw_in, i_sda_in, i_scl};
	for (genvar p = 0; p < 4; p++) begin : g_sync
		always_ff @(posedge i_clk_sys or negedge i_nrst) begin
			if (!i_nrst) begin
				meta_q[p] <= 1'b1;
				sync_q[p] <= 1'b1;
			end else begin
				meta_q[p] <= pins[p];
				sync_q[p] <= meta_q[p];
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			prev_q <= 3'h7;
		end else begin
			prev_q <= sync_q[2:0];
		end
	end

	assign {por_s, sqw_s, sda_s, scl_s} = sync_q;
	assign scl_rise = scl_s & ~prev_q[0];
	assign scl_fall = ~scl_s & prev_q[0];
	assign sda_rise = sda_s & ~prev_q[1];
	assign sda_fall = ~sda_s & prev_q[1];
	assign sqw_rise = sqw_s & ~prev_q[2];
	assign any_edge = scl_rise | scl_fall | sda_rise | sda_fall;
	assign bus_start = sda_fall & scl_s & prev_q[0];
	assign bus_stop = sda_rise & scl_s & prev_q[0];

	// ----------------------------------------------------------------
	// power-on reset override
	// ----------------------------------------------------------------
	rtc_pkg::ovr_step_t ostep_q, ostep_d;
	logic [`OVR_CNT_W-1:0] stab_q, stab_d;
	logic ovr_q, ovr_d, long_ok, por_hold;
	logic [7:0] ctrl1_q, ctrl1_d;
	logic bus_wr;
	logic [7:0] ptr_q, shift_q;

	assign por_hold = por_s & ~ovr_q;
	assign long_ok = (stab_q >= `OVR_CNT_W'(`OVR_STEP_CYC - 1));

	always_comb begin
		ostep_d = ostep_q;
		ovr_d = ovr_q;
		stab_d = any_edge ? '0 : (&stab_q ? stab_q : stab_q + 1'b1);
		if (por_hold && ctrl1_q[`C1_RESET_OVERRIDE_PERMIT]) begin
			case (ostep_q)
				rtc_pkg::OV_IDLE: begin
					if (sda_fall && scl_s && long_ok) ostep_d = rtc_pkg::OV_SDA_LOW;
				end
				rtc_pkg::OV_SDA_LOW: begin
					if (any_edge) ostep_d = (scl_fall && long_ok) ? rtc_pkg::OV_SCL_LOW
						: rtc_pkg::OV_IDLE;
				end
				rtc_pkg::OV_SCL_LOW: begin
					if (any_edge) ostep_d = (sda_rise && long_ok) ? rtc_pkg::OV_SDA_HIGH
						: rtc_pkg::OV_IDLE;
				end
				rtc_pkg::OV_SDA_HIGH: begin
					if (any_edge) begin
						ostep_d = rtc_pkg::OV_IDLE;
						ovr_d = scl_rise & long_ok;
					end
				end
				default: ostep_d = rtc_pkg::OV_IDLE;
			endcase
		end else begin
			ostep_d = rtc_pkg::OV_IDLE;
		end
		if (bus_wr && ptr_q == `OFS_CTRL1 && !shift_q[`C1_RESET_OVERRIDE_PERMIT]) begin
			ovr_d = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			ostep_q <= rtc_pkg::OV_IDLE;
			stab_q <= '0;
			ovr_q <= 1'b0;
		end else begin
			ostep_q <= ostep_d;
			stab_q <= stab_d;
			ovr_q <= ovr_d;
		end
	end

	// ----------------------------------------------------------------
	// tick source and prescaler
	// ----------------------------------------------------------------
	logic [DIV_W-1:0] div_q, div_d;
	logic int_tick, tick, sec_pulse, stop_all, sqw_lvl_q, sqw_lvl_d;

	assign stop_all = ctrl1_q[`C1_STOP] | por_hold;
	assign int_tick = (div_q == DIV_W'(TICK_DIV - 1));
	assign tick = ctrl1_q[`C1_EXT_TICK_TEST_SELECT] ? sqw_rise : int_tick;

	always_comb begin
		div_d = (stop_all || int_tick) ? '0 : div_q + 1'b1;
		sqw_lvl_d = int_tick ? ~sqw_lvl_q : sqw_lvl_q;
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			div_q <= '0;
			sqw_lvl_q <= 1'b0;
		end else begin
			div_q <= div_d;
			sqw_lvl_q <= sqw_lvl_d;
		end
	end

	tick_prescaler #(.WIDTH(`PRESC_W)) u_presc (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_stop(stop_all),
		.i_tick(tick),
		.o_sec(sec_pulse)
	);

	// pin turns input in test mode and stays undriven under reset
	assign o_sqw_oe = ~ctrl1_q[`C1_EXT_TICK_TEST_SELECT] & ~por_hold;
	assign o_sqw_out = sqw_lvl_q;

	// ----------------------------------------------------------------
	// time, control and alarm registers
	// ----------------------------------------------------------------
	logic [7:0] ctrl2_q, ctrl2_d, sec_q, sec_d, min_q, min_d, hour_q, hour_d;
	logic [7:0] date_q, date_d, wday_q, wday_d, rd_data;
	logic [3:0][7:0] al_q, al_d;
	logic adv_q, adv_d, match, match_prev_q, match_prev_d, af_set;

	function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo,
		input logic [7:0] hi);
		if (v >= hi) bcd_inc = {1'b1, lo};
		else if (v[3:0] == 4'h9) bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
		else bcd_inc = {1'b0, v[7:4], v[3:0] + 4'h1};
	endfunction : bcd_inc

	alarm_match u_match (
		.i_min(min_q),
		.i_hour(hour_q),
		.i_date(date_q),
		.i_wday(wday_q),
		.i_al_min(al_q[0]),
		.i_al_hour(al_q[1]),
		.i_al_date(al_q[2]),
		.i_al_wday(al_q[3]),
		.o_match(match)
	);

	// only a count advance into the match raises the flag, never a held match
	assign af_set = adv_q & match & ~match_prev_q;

	always_comb begin
		logic [8:0] s, m, h, d, w;
		s = bcd_inc({1'b0, sec_q[6:0]}, 8'h00, `MAX_SEC);
		m = bcd_inc(min_q, 8'h00, `MAX_SEC);
		h = bcd_inc(hour_q, 8'h00, `MAX_HOUR);
		d = bcd_inc(date_q, `MIN_DATE, `MAX_DATE);
		w = bcd_inc(wday_q, 8'h00, `MAX_WDAY);
		ctrl1_d = ctrl1_q;
		ctrl2_d = ctrl2_q;
		sec_d = sec_q;
		min_d = min_q;
		hour_d = hour_q;
		date_d = date_q;
		wday_d = wday_q;
		al_d = al_q;
		adv_d = 1'b0;
		match_prev_d = adv_q ? match : match_prev_q;
		if (sec_pulse) begin
			sec_d[6:0] = s[6:0];
			if (s[8]) begin
				min_d = m[7:0];
				adv_d = 1'b1;
				if (m[8]) begin
					hour_d = h[7:0];
					if (h[8]) begin
						date_d = d[7:0];
						wday_d = w[7:0];
					end
				end
			end
		end
		if (bus_wr) begin
			case (ptr_q)
				`OFS_CTRL1: ctrl1_d = shift_q & `C1_MASK;
				`OFS_CTRL2: begin
					ctrl2_d[`C2_TITP] = shift_q[`C2_TITP];
					ctrl2_d[`C2_AIE] = shift_q[`C2_AIE];
					ctrl2_d[`C2_TIE] = shift_q[`C2_TIE];
					ctrl2_d[`C2_TF] = ctrl2_q[`C2_TF] & shift_q[`C2_TF];
					ctrl2_d[`C2_AF] = ctrl2_q[`C2_AF] & shift_q[`C2_AF];
				end
				`OFS_SEC: sec_d = shift_q;
				`OFS_MIN: min_d = shift_q & `MASK_MIN;
				`OFS_HOUR: hour_d = shift_q & `MASK_HOUR;
				`OFS_DATE: date_d = shift_q & `MASK_DATE;
				`OFS_WDAY: wday_d = shift_q & `MASK_WDAY;
				`OFS_AL_MIN: al_d[0] = shift_q & (`MASK_MIN | 8'h80);
				`OFS_AL_HOUR: al_d[1] = shift_q & (`MASK_HOUR | 8'h80);
				`OFS_AL_DATE: al_d[2] = shift_q & (`MASK_DATE | 8'h80);
				`OFS_AL_WDAY: al_d[3] = shift_q & (`MASK_WDAY | 8'h80);
				default: ;
			endcase
		end
		// set wins over a clear in the same cycle
		if (af_set) ctrl2_d[`C2_AF] = 1'b1;
		if (por_hold) begin
			// permit survives the held reset, so a cancel sticks until written back
			ctrl1_d = (`CTRL1_RST & ~(8'h01 << `C1_RESET_OVERRIDE_PERMIT)) | (ctrl1_q & (8'h01 << `C1_RESET_OVERRIDE_PERMIT));
			ctrl2_d = `CTRL2_RST;
			sec_d = `SEC_RST;
			adv_d = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl1_q <= `CTRL1_RST;
			ctrl2_q <= `CTRL2_RST;
			sec_q <= `SEC_RST;
			min_q <= 8'h00;
			hour_q <= 8'h00;
			date_q <= `MIN_DATE;
			wday_q <= 8'h00;
			al_q <= '1;
			adv_q <= 1'b0;
			match_prev_q <= 1'b0;
		end else begin
			ctrl1_q <= ctrl1_d;
			ctrl2_q <= ctrl2_d;
			sec_q <= sec_d;
			min_q <= min_d;
			hour_q <= hour_d;
			date_q <= date_d;
			wday_q <= wday_d;
			al_q <= al_d;
			adv_q <= adv_d;
			match_prev_q <= match_prev_d;
		end
	end

	assign o_int_out = 1'b0;
	assign o_int_oe = ctrl2_q[`C2_AF] & ctrl2_q[`C2_AIE];

	always_comb begin
		case (ptr_q)
			`OFS_CTRL1: rd_data = ctrl1_q;
			`OFS_CTRL2: rd_data = ctrl2_q;
			`OFS_SEC: rd_data = sec_q;
			`OFS_MIN: rd_data = min_q;
			`OFS_HOUR: rd_data = hour_q;
			`OFS_DATE: rd_data = date_q;
			`OFS_WDAY: rd_data = wday_q;
			`OFS_AL_MIN: rd_data = al_q[0];
			`OFS_AL_HOUR: rd_data = al_q[1];
			`OFS_AL_DATE: rd_data = al_q[2];
			`OFS_AL_WDAY: rd_data = al_q[3];
			default: rd_data = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// two-wire serial slave
	// ----------------------------------------------------------------
	rtc_pkg::i2c_state_t state_q, state_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] shift_d, ptr_d;
	logic rw_q, rw_d, first_q, first_d, oe_q, oe_d;

	assign bus_wr = (state_q == rtc_pkg::ST_RX) & scl_fall & (cnt_q == 4'h8) & ~first_q;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		shift_d = shift_q;
		ptr_d = ptr_q;
		rw_d = rw_q;
		first_d = first_q;
		oe_d = oe_q;
		case (state_q)
			rtc_pkg::ST_DEV, rtc_pkg::ST_RX: begin
				if (scl_rise) begin
					shift_d = {shift_q[6:0], sda_s};
					cnt_d = cnt_q + 4'h1;
				end else if (scl_fall && cnt_q == 4'h8) begin
					oe_d = 1'b1;
					if (state_q == rtc_pkg::ST_RX) begin
						state_d = rtc_pkg::ST_RX_ACK;
						first_d = 1'b0;
						ptr_d = first_q ? shift_q : ptr_q + 8'h01;
					end else if (shift_q[7:1] == `DEV_ADDR) begin
						state_d = rtc_pkg::ST_DEV_ACK;
						rw_d = shift_q[0];
					end else begin
						state_d = rtc_pkg::ST_IDLE;
						oe_d = 1'b0;
					end
				end
			end
			rtc_pkg::ST_DEV_ACK, rtc_pkg::ST_RX_ACK: begin
				if (scl_fall) begin
					cnt_d = 4'h0;
					if (state_q == rtc_pkg::ST_DEV_ACK && rw_q) begin
						state_d = rtc_pkg::ST_TX;
						shift_d = rd_data;
						ptr_d = ptr_q + 8'h01;
						oe_d = ~rd_data[7];
					end else begin
						state_d = rtc_pkg::ST_RX;
						oe_d = 1'b0;
					end
				end
			end
			rtc_pkg::ST_TX: begin
				if (scl_fall) begin
					shift_d = {shift_q[6:0], 1'b0};
					cnt_d = cnt_q + 4'h1;
					oe_d = ~shift_q[6];
					if (cnt_q == 4'h7) begin
						state_d = rtc_pkg::ST_TX_ACK;
						oe_d = 1'b0;
					end
				end
			end
			rtc_pkg::ST_TX_ACK: begin
				if (scl_rise) begin
					rw_d = sda_s;
				end else if (scl_fall) begin
					cnt_d = 4'h0;
					if (rw_q) begin
						state_d = rtc_pkg::ST_IDLE;
					end else begin
						state_d = rtc_pkg::ST_TX;
						shift_d = rd_data;
						ptr_d = ptr_q + 8'h01;
						oe_d = ~rd_data[7];
					end
				end
			end
			rtc_pkg::ST_IDLE: ;
			default: state_d = rtc_pkg::ST_IDLE;
		endcase
		// in transmit the ack slot reuses rw_q for the sampled acknowledge
		if (state_q == rtc_pkg::ST_TX && scl_fall && cnt_q == 4'h7) rw_d = 1'b1;
		if (bus_start) begin
			state_d = rtc_pkg::ST_DEV;
			cnt_d = 4'h0;
			first_d = 1'b1;
			oe_d = 1'b0;
		end else if (bus_stop) begin
			state_d = rtc_pkg::ST_IDLE;
			oe_d = 1'b0;
		end
		if (por_hold) begin
			state_d = rtc_pkg::ST_IDLE;
			oe_d = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			state_q <= rtc_pkg::ST_IDLE;
			cnt_q <= 4'h0;
			shift_q <= 8'h00;
			ptr_q <= 8'h00;
			rw_q <= 1'b0;
			first_q <= 1'b1;
			oe_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			shift_q <= shift_d;
			ptr_q <= ptr_d;
			rw_q <= rw_d;
			first_q <= first_d;
			oe_q <= oe_d;
		end
	end

	assign o_sda_out = 1'b0;
	assign o_sda_oe = oe_q;
endmodule : rtc_alarm_test_i2c_slave

/* File: verification/rtc_alarm_test_i2c_slave_assertions.sv */
// rtc_alarm_test_i2c_slave_assertions: pin-level timing checks on the slave outputs
// assumes the top ports only; pins reach the logic through two register stages, and the outputs through one more
module rtc_alarm_test_i2c_slave_assertions (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_por_active,
	input wire logic i_scl,
	input wire logic i_sda_in,
	input wire logic o_sda_out,
	input wire logic o_sda_oe,
	input wire logic i_sqw_in,
	input wire logic o_sqw_out,
	input wire logic o_sqw_oe,
	input wire logic o_int_out,
	input wire logic o_int_oe
);
	default clocking dc @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_nrst);
	a_sda_open_drain: assert property (o_sda_out == 1'b0)
		else $error("data pin output not low");
	a_int_open_drain: assert property (o_int_out == 1'b0)
		else $error("interrupt pin output not low");
	a_sda_moves_low: assert property ($changed(o_sda_oe) |-> !$past(i_scl, 3))
		else $error("data drive changed while clock high");
	// a cancelled override cuts an ack short, so this one rests while held in reset
	a_ack_held: assert property (disable iff (!i_nrst || i_por_active)
		$rose(o_sda_oe) |=> o_sda_oe [*4])
		else $error("data drive released too soon");
	a_quiet_after_start: assert property (
		$fell(i_sda_in) && i_scl |-> ##4 !o_sda_oe [*8])
		else $error("slave drove data during address");
	a_free_after_stop: assert property (
		$rose(i_sda_in) && i_scl |-> ##4 !o_sda_oe [*4])
		else $error("slave drove data after stop");
	a_reset_pins_idle: assert property ($rose(i_nrst) |-> !o_sda_oe && !o_int_oe)
		else $error("pins driven right after reset");
	a_sqw_off_reset: assert property ($rose(i_nrst) |-> !o_sqw_oe)
		else $error("square wave driven right after reset");
endmodule : rtc_alarm_test_i2c_slave_assertions

bind rtc_alarm_test_i2c_slave rtc_alarm_test_i2c_slave_assertions chk (.*);

/* File: verification/i2c_master_model.sv */
// i2c_master_model: bit-level two-wire bus master with an open-drain data pull
// assumes a pull-up on the data line outside; the clock line is driven push-pull
module i2c_master_model (
	output logic o_scl = 1'b1,
	output logic o_sda_pull = 1'b0,
	input wire logic i_sda
);
	timeunit 1ns;
	timeprecision 1ns;
	// 100 ns per clock phase keeps both phases above the 50 ns minimum
	task automatic bit_clk(input logic d, output logic s);
		o_sda_pull = !d;
		#50;
		o_scl = 1'b1;
		#50;
		s = i_sda;
		#50;
		o_scl = 1'b0;
		#50;
	endtask : bit_clk
	task start_c();
		o_sda_pull = 1'b0;
		#50;
		o_scl = 1'b1;
		#100;
		o_sda_pull = 1'b1;
		#100;
		o_scl = 1'b0;
		#50;
	endtask : start_c
	task stop_c();
		o_sda_pull = 1'b1;
		#50;
		o_scl = 1'b1;
		#100;
		o_sda_pull = 1'b0;
		#100;
	endtask : stop_c
	task automatic put(input logic [7:0] b, output logic a);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_clk(b[i], s);
		end
		bit_clk(1'b1, s);
		a = !s;
	endtask : put
	task automatic get(output logic [7:0] b, input logic nack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_clk(1'b1, s);
			b[i] = s;
		end
		bit_clk(nack, s);
	endtask : get
	task pins(input logic c, input logic d);
		o_scl = c;
		o_sda_pull = !d;
		#1100;
	endtask : pins
endmodule : i2c_master_model

/* File: verification/testbench.sv */
// testbench: alarm, test tick, reset override and serial slave scenarios
// assumes the design files and the master model are compiled first
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LIMIT = 40000;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic por = 1'b0;
	logic square_wave_pin = 1'b0;
	logic scl;
	logic pull;
	logic sda_out, sda_oe, sqw_out, sqw_oe, int_out, int_oe;
	int failures = 0;
	int n_checks = 0;
	int cyc = 0;
	// released data line floats high through the bus pull-up
	wire logic sda_w = !pull && !(sda_oe && !sda_out);
	wire logic sqw_w = sqw_oe ? sqw_out : square_wave_pin;
	rtc_alarm_test_i2c_slave #(.TICK_DIV(64)) uut (
		.i_clk_sys(clk), .i_nrst(nrst), .i_por_active(por), .i_scl(scl),
		.i_sda_in(sda_w), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_sqw_in(sqw_w),
		.o_sqw_out(sqw_out), .o_sqw_oe(sqw_oe), .o_int_out(int_out), .o_int_oe(int_oe)
	);
	i2c_master_model mst (.o_scl(scl), .o_sda_pull(pull), .i_sda(sda_w));
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			failures++;
			report_and_stop();
		end
	end
	task report_and_stop();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : report_and_stop
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic probe(input logic [7:0] adr, input logic exp);
		logic a;
		mst.start_c();
		mst.put(adr, a);
		mst.stop_c();
		chk({7'h00, a}, {7'h00, exp});
	endtask : probe
	task automatic wr(input logic [7:0] p, input logic [7:0] q[$]);
		logic a;
		mst.start_c();
		mst.put(8'hA2, a);
		chk({7'h00, a}, 8'h01);
		mst.put(p, a);
		foreach (q[i]) begin
			mst.put(q[i], a);
			chk({7'h00, a}, 8'h01);
		end
		mst.stop_c();
	endtask : wr
	task automatic rd(input logic [7:0] p, input logic [7:0] q[$]);
		logic a;
		logic [7:0] b;
		mst.start_c();
		mst.put(8'hA2, a);
		mst.put(p, a);
		mst.start_c();
		mst.put(8'hA3, a);
		chk({7'h00, a}, 8'h01);
		foreach (q[i]) begin
			mst.get(b, i == q.size() - 1);
			chk(b, q[i]);
		end
		mst.stop_c();
	endtask : rd
	task edges(input int n);
		repeat (n) begin
			square_wave_pin = 1'b1;
			#40;
			square_wave_pin = 1'b0;
			#40;
		end
	endtask : edges
	task t_reset();
		logic b;
		rd(8'h00, {8'h08, 8'h00, 8'h80});
		rd(8'h07, {8'h00});
		chk({7'h00, sqw_oe}, 8'h01);
		// one internal tick falls in any 64-cycle window
		b = sqw_out;
		repeat (64) @(negedge clk);
		chk({7'h00, sqw_out}, {7'h00, ~b});
	endtask : t_reset
	task t_regs();
		wr(8'h09, {8'h85, 8'h97, 8'hA1, 8'h83});
		rd(8'h09, {8'h85, 8'h97, 8'hA1, 8'h83});
		probe(8'hA0, 1'b0);
		probe(8'hA4, 1'b0);
	endtask : t_regs
	// only the minute field is enabled; the disabled hour holds a value that differs
	task t_alarm();
		wr(8'h00, {8'hA0});
		chk({7'h00, sqw_oe}, 8'h00);
		wr(8'h01, {8'h02, 8'h59, 8'h04, 8'h00});
		wr(8'h09, {8'h05});
		wr(8'h00, {8'h80});
		edges(31);
		rd(8'h02, {8'h59});
		chk({7'h00, int_oe}, 8'h00);
		edges(1);
		rd(8'h01, {8'h0A, 8'h00, 8'h05});
		chk({7'h00, int_oe}, 8'h01);
		wr(8'h01, {8'h0A});
		chk({7'h00, int_oe}, 8'h01);
		wr(8'h01, {8'h02});
		chk({7'h00, int_oe}, 8'h00);
		edges(64);
		rd(8'h01, {8'h02, 8'h01, 8'h05});
	endtask : t_alarm
	task ovr_seq();
		mst.pins(1'b1, 1'b1);
		mst.pins(1'b1, 1'b0);
		mst.pins(1'b0, 1'b0);
		mst.pins(1'b0, 1'b1);
		mst.pins(1'b1, 1'b1);
	endtask : ovr_seq
	task t_override();
		logic a;
		// the alarm scenario cleared the permit, so it is written back to 1 before the sequence
		wr(8'h00, {8'h08});
		@(negedge clk);
		por = 1'b1;
		repeat (10) @(negedge clk);
		probe(8'hA2, 1'b0);
		ovr_seq();
		rd(8'h01, {8'h00});
		// the cancel puts the held reset back at once and cuts the data ack short
		mst.start_c();
		mst.put(8'hA2, a);
		mst.put(8'h00, a);
		mst.put(8'h00, a);
		mst.stop_c();
		chk({7'h00, a}, 8'h00);
		probe(8'hA2, 1'b0);
		// permit still 0: the same sequence must not release the reset again
		ovr_seq();
		probe(8'hA2, 1'b0);
		por = 1'b0;
	endtask : t_override
	initial begin
		repeat (6) @(negedge clk);
		nrst = 1'b1;
		repeat (10) @(negedge clk);
		t_reset();
		t_regs();
		t_alarm();
		t_override();
		report_and_stop();
	end
endmodule : testbench
